// file: core/set_pkg.sv
// Purpose: Shared constants and types for the serial memory target port.
// Assumes: One system clock of 20 MHz; the serial clock is a separate domain.
// Notes:   All figures used by the port and its crossing FIFO live here.

package set_pkg;

   // ------------------------------------------------------------------
   // Array organisation
   // ------------------------------------------------------------------
   localparam int BYTE_BITS = 8;
   localparam int PAGE_BYTES = 64;
   localparam int PAGE_W = 6;
   localparam int SMALL_PAGES = 256;
   localparam int LARGE_PAGES = 512;
   localparam int SMALL_ADDR_W = 14;
   localparam int LARGE_ADDR_W = 15;

   // ------------------------------------------------------------------
   // Bus addressing
   // ------------------------------------------------------------------
   localparam int MAX_DEVICES = 8;
   localparam int SEL_W = 3;
   localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
   localparam logic [3:0] LAST_BIT = 4'h7;
   localparam logic [3:0] ACK_BIT = 4'h8;
   localparam int RW_POS = 0;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int WR_TIME_MS = 5;
   localparam int NS_PER_MS = 1000000;
   // Longest time, so rounded down
   localparam int WR_CYCLES = (WR_TIME_MS * NS_PER_MS) / CLK_PERIOD_NS;
   localparam logic [2:0] FLUSH_CYCLES = 3'h6;
   localparam int FIFO_DEPTH = 16;

   // ------------------------------------------------------------------
   // State types
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      L_DEV = 3'b000,
      L_ADH = 3'b001,
      L_ADL = 3'b010,
      L_WDATA = 3'b011,
      L_RDATA = 3'b100,
      L_IGNORE = 3'b101
   } set_link_st_t;

   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_FLUSH = 2'b01,
      S_PROG = 2'b10
   } set_sys_st_t;

endpackage : set_pkg

// file: core/set_fifo.sv
// Purpose: Dual-clock FIFO carrying received write bytes to the system side.
// Assumes: DEPTH is a power of two; both resets are asserted together.
// Notes:   Gray-coded pointers cross through two flops on each side.

`timescale 1ns/100ps

module set_fifo #(
   parameter int WIDTH = 23,
   parameter int DEPTH = 16
) (
   input wire logic wr_clk_in,
   input wire logic wr_rst_b_in,
   input wire logic wr_valid_in,
   output logic wr_ready_out,
   input wire logic [WIDTH-1:0] wr_data_in,
   input wire logic rd_clk_in,
   input wire logic rd_rst_b_in,
   input wire logic rd_ce_in,
   output logic rd_valid_out,
   input wire logic rd_ready_in,
   output logic [WIDTH-1:0] rd_data_out
);

   localparam int IDX_W = $clog2(DEPTH);
   localparam int PTR_W = IDX_W + 1;

   if (DEPTH < 4 || (1 << IDX_W) != DEPTH) begin : g_bad_depth
      $error("set_fifo: DEPTH must be a power of two of at least 4");
   end

   logic [WIDTH-1:0] store [DEPTH];
   logic [PTR_W-1:0] wr_bin, wr_gray, rd_bin, rd_gray;
   logic [PTR_W-1:0] rg_m, rg_s, wg_m, wg_s;
   logic [PTR_W-1:0] next_wr_bin, next_rd_bin;
   wire push = wr_valid_in & wr_ready_out;
   wire pop = rd_valid_out & rd_ready_in & rd_ce_in;

   assign next_wr_bin = wr_bin + 1'b1;
   assign next_rd_bin = rd_bin + 1'b1;
   // Full when the write pointer is one lap ahead of the read pointer
   assign wr_ready_out = wr_gray != {~rg_s[PTR_W-1:PTR_W-2], rg_s[PTR_W-3:0]};
   assign rd_valid_out = rd_gray != wg_s;
   assign rd_data_out = store[rd_bin[IDX_W-1:0]];

   // ------------------------------------------------------------------
   // Write side
   // ------------------------------------------------------------------
   always_ff @(posedge wr_clk_in) begin
      if (push) begin
         store[wr_bin[IDX_W-1:0]] <= wr_data_in;
      end
   end

   always_ff @(posedge wr_clk_in or negedge wr_rst_b_in) begin
      if (!wr_rst_b_in) begin
         wr_bin <= '0;
         wr_gray <= '0;
         rg_m <= '0;
         rg_s <= '0;
      end else begin
         rg_m <= rd_gray;
         rg_s <= rg_m;
         if (push) begin
            wr_bin <= next_wr_bin;
            wr_gray <= next_wr_bin ^ (next_wr_bin >> 1);
         end
      end
   end

   // ------------------------------------------------------------------
   // Read side
   // ------------------------------------------------------------------
   always_ff @(posedge rd_clk_in or negedge rd_rst_b_in) begin
      if (!rd_rst_b_in) begin
         rd_bin <= '0;
         rd_gray <= '0;
         wg_m <= '0;
         wg_s <= '0;
      end else if (rd_ce_in) begin
         wg_m <= wr_gray;
         wg_s <= wg_m;
         if (pop) begin
            rd_bin <= next_rd_bin;
            rd_gray <= next_rd_bin ^ (next_rd_bin >> 1);
         end
      end
   end

endmodule : set_fifo

// file: core/set_target.sv
// Purpose: Two-wire serial target port of a byte-wide nonvolatile array.
// Assumes: The serial clock clocks bit logic; framing is seen on clk_sys_in.
// Notes:   The array is read by the link side only while busy is low; bytes staged before a repeated start stay unwritten until stop.
//
// Summary of operation
// - Incoming bits are sampled on serial clock rise, outgoing bits change after fall.
// - The data line is only pulled low or released, never driven high.
// - Up to eight ports share a bus, each strapped to its own select code.
// - Unconnected select pins read as zero by pad pull-down; grounding is advised.
// - With write protect low, reads and writes act normally.
// - With write protect high at frame start, no array byte is changed.
// - Small variant: 256 pages of 64 bytes, 14-bit word address.
// - Large variant: 512 pages of 64 bytes, 15-bit word address.
// - Page writes take up to 64 bytes within one page; partial pages allowed.
// - A write self-times its programming within 5 ms on the system clock, no serial clocks needed.
// - Data falling while the clock is high starts every command.
// - Data rising while the clock is high stops; the port goes to standby once the flush and any programming end.
// - Data changes only while the clock is low; high-phase changes are framing.
// - Bytes are eight bits; the port pulls data low in the ninth clock to acknowledge.

`timescale 1ns/100ps

module set_target #(
   parameter int ADDR_W = set_pkg::LARGE_ADDR_W,
   parameter int WR_CYCLES = set_pkg::WR_CYCLES,
   parameter int FIFO_DEPTH = set_pkg::FIFO_DEPTH
) (
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   input wire logic ce_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   input wire logic [set_pkg::SEL_W-1:0] addr_select_pins_in,
   input wire logic wp_in,
   output logic busy_out,
   output logic standby_out
);

   localparam int MEM_BYTES = 1 << ADDR_W;
   localparam int PAGE_IDX_W = ADDR_W - set_pkg::PAGE_W;
   localparam int HI_W = ADDR_W - set_pkg::BYTE_BITS;
   localparam int ENTRY_W = ADDR_W + set_pkg::BYTE_BITS;
   localparam int TMR_W = $clog2(WR_CYCLES + 1);

   if (ADDR_W != set_pkg::SMALL_ADDR_W && ADDR_W != set_pkg::LARGE_ADDR_W) begin : g_bad_addr
      $error("set_target: ADDR_W must be 14 or 15");
   end
   if (WR_CYCLES < 1) begin : g_bad_wr
      $error("set_target: WR_CYCLES must be at least 1");
   end

   // ------------------------------------------------------------------
   // System side: pin synchronisers and framing
   // ------------------------------------------------------------------
   logic scl_m, scl_s, sda_m, sda_s, sda_d, wp_m, wp_s;
   logic link_run, start_q, wp_frame;
   logic link_rst_b;

   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_d <= 1'b1;
         wp_m <= 1'b0;
         wp_s <= 1'b0;
      end else if (ce_in) begin
         scl_m <= scl_in;
         scl_s <= scl_m;
         sda_m <= sda_in;
         sda_s <= sda_m;
         sda_d <= sda_s;
         wp_m <= wp_in;
         wp_s <= wp_m;
      end
   end

   // Changes in the clock-high phase are framing, not data
   wire start_det = scl_s & sda_d & ~sda_s;
   wire stop_det = scl_s & ~sda_d & sda_s;

   // A repeated start drops the link side for one cycle so it restarts cleanly
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         link_run <= 1'b0;
         start_q <= 1'b0;
         wp_frame <= 1'b0;
      end else if (ce_in) begin
         start_q <= start_det;
         if (start_det || stop_det) begin
            link_run <= 1'b0;
         end else if (start_q) begin
            link_run <= 1'b1;
         end
         if (start_det) begin
            wp_frame <= wp_s;
         end
      end
   end

   assign link_rst_b = rst_b_in & link_run;

   // ------------------------------------------------------------------
   // Link side: bit engine on the serial clock
   // ------------------------------------------------------------------
   set_pkg::set_link_st_t lst;
   logic [3:0] bit_cnt;
   logic [6:0] shift_r;
   logic ack_q;
   logic [HI_W-1:0] addr_hi;
   logic [ADDR_W-1:0] ptr;
   logic busy_m, busy_l;
   logic [set_pkg::SEL_W-1:0] sel_m, sel_l;
   logic drive;
   logic fifo_wr_ready;
   logic [7:0] rd_byte;
   logic [7:0] mem [MEM_BYTES];

   wire [7:0] byte_w = {shift_r, sda_in};
   wire last_bit = bit_cnt == set_pkg::LAST_BIT;
   wire ack_slot = bit_cnt == set_pkg::ACK_BIT;
   // Unconnected select pins arrive as zero from the pad pull-down
   wire sel_hit = byte_w[3:1] == sel_l;
   wire dev_hit = (byte_w[7:4] == set_pkg::DEV_TYPE_CODE) & sel_hit & ~busy_l;
   wire is_read = byte_w[set_pkg::RW_POS];
   wire push = (lst == set_pkg::L_WDATA) & last_bit & fifo_wr_ready;
   wire host_ack = (lst == set_pkg::L_RDATA) & ack_slot & ~ack_q & ~sda_in;
   wire host_nak = (lst == set_pkg::L_RDATA) & ack_slot & ~ack_q & sda_in;
   wire [3:0] next_bit_cnt = ack_slot ? 4'h0 : bit_cnt + 4'h1;
   wire [2:0] tx_idx = 3'(set_pkg::LAST_BIT - bit_cnt);
   wire [ADDR_W-1:0] next_wr_ptr = {ptr[ADDR_W-1:set_pkg::PAGE_W],
                                    ptr[set_pkg::PAGE_W-1:0] + 1'b1};
   wire next_drive = ack_slot ? ack_q :
                     ((lst == set_pkg::L_RDATA) ? ~rd_byte[tx_idx] : 1'b0);

   assign rd_byte = mem[ptr];

   // Straps and busy are slow levels; two flops each on the serial clock
   always_ff @(posedge scl_in or negedge link_rst_b) begin
      if (!link_rst_b) begin
         busy_m <= 1'b0;
         busy_l <= 1'b0;
         sel_m <= '0;
         sel_l <= '0;
      end else begin
         busy_m <= busy_out;
         busy_l <= busy_m;
         sel_m <= addr_select_pins_in;
         sel_l <= sel_m;
      end
   end

   always_ff @(posedge scl_in or negedge link_rst_b) begin
      if (!link_rst_b) begin
         lst <= set_pkg::L_DEV;
         bit_cnt <= 4'h0;
         shift_r <= 7'h00;
         ack_q <= 1'b0;
         addr_hi <= '0;
      end else begin
         bit_cnt <= next_bit_cnt;
         if (!ack_slot) begin
            shift_r <= byte_w[6:0];
         end
         if (host_nak) begin
            lst <= set_pkg::L_IGNORE;
         end
         if (last_bit) begin
            case (lst)
               set_pkg::L_DEV: begin
                  ack_q <= dev_hit;
                  if (!dev_hit) begin
                     lst <= set_pkg::L_IGNORE;
                  end else if (is_read) begin
                     lst <= set_pkg::L_RDATA;
                  end else begin
                     lst <= set_pkg::L_ADH;
                  end
               end
               set_pkg::L_ADH: begin
                  ack_q <= 1'b1;
                  addr_hi <= byte_w[HI_W-1:0];
                  lst <= set_pkg::L_ADL;
               end
               set_pkg::L_ADL: begin
                  ack_q <= 1'b1;
                  lst <= set_pkg::L_WDATA;
               end
               set_pkg::L_WDATA: begin
                  // A full FIFO refuses the byte with no acknowledge
                  ack_q <= fifo_wr_ready;
               end
               default: begin
                  ack_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // Current address survives frames, so it sits on the main reset
   always_ff @(posedge scl_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ptr <= '0;
      end else if (link_run) begin
         if (lst == set_pkg::L_ADL && last_bit) begin
            ptr <= {addr_hi, byte_w};
         end else if (push) begin
            ptr <= next_wr_ptr;
         end else if (host_ack) begin
            ptr <= ptr + 1'b1;
         end
      end
   end

   // Drive changes only after the falling edge, while the clock is low
   always_ff @(negedge scl_in or negedge link_rst_b) begin
      if (!link_rst_b) begin
         drive <= 1'b0;
      end else begin
         drive <= next_drive;
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe_out = drive;

   // ------------------------------------------------------------------
   // Crossing FIFO for write bytes
   // ------------------------------------------------------------------
   logic fifo_rd_valid;
   logic fifo_rd_ready;
   logic [ENTRY_W-1:0] fifo_rd_data;

   set_fifo #(
      .WIDTH(ENTRY_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .wr_clk_in(scl_in),
      .wr_rst_b_in(rst_b_in),
      .wr_valid_in(push),
      .wr_ready_out(fifo_wr_ready),
      .wr_data_in({ptr, byte_w}),
      .rd_clk_in(clk_sys_in),
      .rd_rst_b_in(rst_b_in),
      .rd_ce_in(ce_in),
      .rd_valid_out(fifo_rd_valid),
      .rd_ready_in(fifo_rd_ready),
      .rd_data_out(fifo_rd_data)
   );

   // ------------------------------------------------------------------
   // System side: page staging and self-timed programming
   // ------------------------------------------------------------------
   set_pkg::set_sys_st_t sst;
   logic [TMR_W-1:0] timer;
   logic [2:0] flush_cnt;
   logic [PAGE_IDX_W-1:0] page_r;
   logic [set_pkg::PAGE_BYTES-1:0] mask;
   logic [7:0] stage [set_pkg::PAGE_BYTES];

   wire [ADDR_W-1:0] in_addr = fifo_rd_data[ENTRY_W-1:set_pkg::BYTE_BITS];
   wire [7:0] in_byte = fifo_rd_data[set_pkg::BYTE_BITS-1:0];
   wire [PAGE_IDX_W-1:0] in_page = in_addr[ADDR_W-1:set_pkg::PAGE_W];
   wire [set_pkg::PAGE_W-1:0] in_col = in_addr[set_pkg::PAGE_W-1:0];
   wire pop = fifo_rd_valid & fifo_rd_ready & ce_in;
   // First byte fixes the page; stray bytes of another page are dropped
   wire page_ok = (mask == '0) | (in_page == page_r);
   wire take = pop & ~wp_frame & page_ok;
   wire commit = ce_in & (sst == set_pkg::S_PROG) & (timer == '0);

   assign fifo_rd_ready = sst != set_pkg::S_PROG;

   for (genvar i = 0; i < set_pkg::PAGE_BYTES; i++) begin : g_page
      always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
         if (!rst_b_in) begin
            mask[i] <= 1'b0;
            stage[i] <= 8'h00;
         end else if (commit) begin
            mask[i] <= 1'b0;
         end else if (take && in_col == set_pkg::PAGE_W'(i)) begin
            mask[i] <= 1'b1;
            stage[i] <= in_byte;
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         page_r <= '0;
      end else if (take && mask == '0) begin
         page_r <= in_page;
      end
   end

   // Stop starts a short flush so bytes still crossing are caught
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sst <= set_pkg::S_IDLE;
         timer <= '0;
         flush_cnt <= 3'h0;
      end else if (ce_in) begin
         case (sst)
            set_pkg::S_IDLE: begin
               if (stop_det) begin
                  sst <= set_pkg::S_FLUSH;
                  flush_cnt <= set_pkg::FLUSH_CYCLES;
               end
            end
            set_pkg::S_FLUSH: begin
               if (flush_cnt != 3'h0) begin
                  flush_cnt <= flush_cnt - 3'h1;
               end else if (mask != '0) begin
                  sst <= set_pkg::S_PROG;
                  timer <= TMR_W'(WR_CYCLES - 1);
               end else begin
                  sst <= set_pkg::S_IDLE;
               end
            end
            set_pkg::S_PROG: begin
               if (timer == '0) begin
                  sst <= set_pkg::S_IDLE;
               end else begin
                  timer <= timer - 1'b1;
               end
            end
            default: begin
               sst <= set_pkg::S_IDLE;
            end
         endcase
      end
   end

   // Nonvolatile array, so it takes no reset
   always_ff @(posedge clk_sys_in) begin
      if (commit) begin
         for (int j = 0; j < set_pkg::PAGE_BYTES; j++) begin
            if (mask[j]) begin
               mem[{page_r, set_pkg::PAGE_W'(j)}] <= stage[j];
            end
         end
      end
   end

   // Busy makes the port refuse its address until programming ends
   assign busy_out = sst != set_pkg::S_IDLE;
   assign standby_out = (sst == set_pkg::S_IDLE) & ~link_run;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   chk_ack_match: assert property (
      @(posedge scl_in) disable iff (!link_rst_b)
      (lst == set_pkg::L_DEV && last_bit && dev_hit) |=> ack_q && bit_cnt == set_pkg::ACK_BIT)
      else $error("matching address not acknowledged");

   chk_nak_other: assert property (
      @(posedge scl_in) disable iff (!link_rst_b)
      (lst == set_pkg::L_DEV && last_bit && !sel_hit) |=> !ack_q ##1 lst == set_pkg::L_IGNORE)
      else $error("foreign select code answered");

   chk_drive_slots: assert property (
      @(posedge scl_in) disable iff (!link_rst_b)
      sda_oe_out |-> (ack_slot || lst == set_pkg::L_RDATA))
      else $error("data line pulled outside ack or read slot");

   chk_page_stay: assert property (
      @(posedge scl_in) disable iff (!rst_b_in)
      push |=> ptr[ADDR_W-1:set_pkg::PAGE_W] == $past(ptr[ADDR_W-1:set_pkg::PAGE_W]))
      else $error("page write left its page");

   chk_busy_nak: assert property (
      @(posedge scl_in) disable iff (!link_rst_b)
      (busy_l && lst == set_pkg::L_DEV && last_bit) |=> !ack_q)
      else $error("address acknowledged while programming");

   chk_wp_block: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (wp_frame && ce_in && !commit) |=> $stable(mask))
      else $error("staged bytes changed under write protect");

   chk_wr_time: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (sst == set_pkg::S_PROG) |-> timer < TMR_W'(WR_CYCLES))
      else $error("programming time above limit");

   chk_commit_end: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      commit |=> mask == '0 && sst == set_pkg::S_IDLE)
      else $error("commit did not end programming");

   chk_start_drop: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (start_det && ce_in) |=> !link_run ##1 (link_run || !ce_in || stop_det || start_det))
      else $error("start did not restart the link side");

   chk_stop_end: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (stop_det && ce_in && sst == set_pkg::S_IDLE) |=> !link_run && busy_out)
      else $error("stop did not end the frame");

endmodule : set_target

// file: test/set_ctl_model.sv
// Purpose: Behavioural two-wire bus controller facing the target port.
// Assumes: lk_in is the controller's own clock; sda_in is the resolved line.
// Notes:   Phases of 5 ticks or more keep framing visible to the 50 ns side.
`timescale 1ns/100ps
module set_ctl_model (
   input wire logic lk_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_low_out
);
   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end
   task automatic w(input int n);
      repeat (n) @(posedge lk_in);
   endtask : w
   // Long setup and hold so the sampled framing is seen
   task automatic start_c();
      // Let the clock fall settle first, or the data change reads as framing
      w(2);
      sda_low_out = 1'b0;
      w(5);
      scl_out = 1'b1;
      w(15);
      sda_low_out = 1'b1;
      w(15);
      scl_out = 1'b0;
      w(5);
   endtask : start_c
   task automatic stop_c();
      w(2);
      sda_low_out = 1'b1;
      w(5);
      scl_out = 1'b1;
      w(15);
      sda_low_out = 1'b0;
      // Short tail so busy is still seen during the flush
      w(5);
   endtask : stop_c
   task automatic bit_c(input logic b, output logic r);
      w(2);
      sda_low_out = !b;
      w(3);
      scl_out = 1'b1;
      w(2);
      r = sda_in;
      w(3);
      scl_out = 1'b0;
   endtask : bit_c
   // Released bits read back the line, so ff is sent when reading
   task automatic byte_c(input logic [7:0] d, input logic ack_bit, output logic [7:0] q,
                         output logic acked);
      logic a;
      for (int i = 7; i >= 0; i--) bit_c(d[i], q[i]);
      bit_c(ack_bit, a);
      acked = !a;
   endtask : byte_c
endmodule : set_ctl_model

// file: test/tb_top.sv
// Purpose: Self-checking bench for the serial memory target port.
// Assumes: Programming time shortened to 200 cycles; large variant.
// Notes:   Only written bytes are read back, unwritten ones are unknown.
`timescale 1ns/100ps
module tb_top;
   logic clk_sys_in = 0, lk = 0, rst_b_in = 0, ce_in = 1, wp_in = 0;
   logic [2:0] sel = 3'h0;
   logic scl, ctl_low, sda_oe, sda_o, busy, stby;
   logic [31:0] seed = 32'h8a1f5aa7;
   logic [7:0] mem [int];
   int error_cnt = 0, n_tests = 0;
   // Pull-up: line is high unless someone pulls it low
   wire sda_line = !(ctl_low | (sda_oe & !sda_o));
   initial forever #25 clk_sys_in = !clk_sys_in;
   initial begin
      #7;
      forever #16 lk = !lk;
   end
   set_target #(.ADDR_W(15), .WR_CYCLES(200)) dut (.clk_sys_in(clk_sys_in),
      .rst_b_in(rst_b_in), .ce_in(ce_in), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_o),
      .sda_oe_out(sda_oe), .addr_select_pins_in(sel), .wp_in(wp_in), .busy_out(busy),
      .standby_out(stby));
   set_ctl_model ctl (.lk_in(lk), .sda_in(sda_line), .scl_out(scl), .sda_low_out(ctl_low));
   function automatic logic [31:0] next_rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction : next_rnd
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic finish_test();
      $display("checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test
   task automatic settle();
      for (int k = 0; k < 400 && stby !== 1'b1; k++) @(negedge clk_sys_in);
      check(stby, 1);
      if (stby !== 1'b1) finish_test();
   endtask : settle
   task automatic head(input logic [2:0] s, input logic [14:0] a, input logic exp_ack);
      logic [7:0] q;
      logic ak;
      ctl.start_c();
      ctl.byte_c({set_pkg::DEV_TYPE_CODE, s, 1'b0}, 1'b1, q, ak);
      check(ak, exp_ack);
      if (exp_ack) begin
         ctl.byte_c({1'b0, a[14:8]}, 1'b1, q, ak);
         check(ak, 1);
         ctl.byte_c(a[7:0], 1'b1, q, ak);
         check(ak, 1);
      end
   endtask : head
   task automatic wr(input logic [14:0] a, input int n, input logic prot);
      logic [7:0] q;
      logic ak;
      logic [31:0] r;
      head(sel, a, 1);
      for (int i = 0; i < n; i++) begin
         r = next_rnd();
         ctl.byte_c(r[7:0], 1'b1, q, ak);
         check(ak, 1);
         if (!prot) mem[{a[14:6], 6'(a[5:0] + i)}] = r[7:0];
      end
      ctl.stop_c();
      check(busy, 1);
      // Address must be refused while the write programs
      if (n == 1 && !prot) begin
         head(sel, a, 0);
         ctl.stop_c();
      end
      settle();
   endtask : wr
   task automatic rd(input logic [14:0] a, input int n);
      logic [7:0] q;
      logic ak;
      head(sel, a, 1);
      ctl.start_c();
      ctl.byte_c({set_pkg::DEV_TYPE_CODE, sel, 1'b1}, 1'b1, q, ak);
      check(ak, 1);
      for (int i = 0; i < n; i++) begin
         ctl.byte_c(8'hff, i == n - 1, q, ak);
         check(q, mem[15'(a + i)]);
      end
      ctl.stop_c();
      settle();
   endtask : rd
   initial begin
      logic [31:0] r;
      logic [14:0] a;
      repeat (8) @(negedge clk_sys_in);
      rst_b_in = 1;
      repeat (4) @(negedge clk_sys_in);
      check(stby, 1);
      for (int t = 0; t < 4; t++) begin
         r = next_rnd();
         @(negedge clk_sys_in);
         sel = r[23:21];
         a = {r[14:6], 1'b0, r[4:0]};
         wr(a, 1 + r[18:16], 0);
         rd(a, 1 + r[18:16]);
      end
      check(sda_o, 0);
      for (int s = 0; s < 8; s++) begin
         @(negedge clk_sys_in);
         sel = 3'(s);
         head(3'(s + 1 + (s % 3)), 15'h0, 0);
         ctl.stop_c();
         settle();
      end
      wr(15'h7ffe, 4, 0);
      rd(15'h7ffe, 2);
      rd(15'h7fc0, 2);
      wr(15'h1000, 64, 0);
      rd(15'h1000, 64);
      wr(15'h0040, 1, 0);
      wr(15'h4040, 1, 0);
      rd(15'h0040, 1);
      @(negedge clk_sys_in);
      wp_in = 1;
      wr(15'h0040, 1, 1);
      @(negedge clk_sys_in);
      wp_in = 0;
      rd(15'h0040, 1);
      finish_test();
   end
endmodule : tb_top
